// ### verilog/branch_call_pkg.sv
// Constants for the control-transfer decode and execute unit
package branch_call_pkg;
    localparam int          XLEN          = 32;        // Data and address width
    localparam int          REG_IDX_W     = 5;         // Register index width
    localparam int          OP_W          = 6;         // Primary opcode width
    localparam int          OPX_W         = 6;         // Extended opcode width
    localparam int          OFS_W         = 16;        // Relative offset width
    localparam int          JT_W          = 26;        // Jump target width
    localparam int          TT_W          = 5;         // Trap type width
    // Field positions
    localparam int          RA_HI         = 31;
    localparam int          RA_LO         = 27;
    localparam int          RB_HI         = 26;
    localparam int          RB_LO         = 22;
    localparam int          OFS_HI        = 21;
    localparam int          OFS_LO        = 6;
    localparam int          OP_HI         = 5;
    localparam int          OP_LO         = 0;
    localparam int          OPX_HI        = 16;
    localparam int          OPX_LO        = 11;
    localparam int          JT_HI         = 31;
    localparam int          JT_LO         = 6;
    localparam int          TT_HI         = 10;
    localparam int          TT_LO         = 6;
    localparam int          REGION_HI     = 31;
    localparam int          REGION_LO     = 28;
    // Primary opcodes
    localparam logic [5:0]  OP_CALL       = 6'h00;
    localparam logic [5:0]  OP_RELJUMP    = 6'h06;
    localparam logic [5:0]  OP_BLT        = 6'h16;
    localparam logic [5:0]  OP_BNE        = 6'h1E;
    localparam logic [5:0]  OP_BLTU       = 6'h36;
    localparam logic [5:0]  OP_RTYPE      = 6'h3A;
    // Extended opcodes of the register format
    localparam logic [5:0]  OPX_TRAP      = 6'h34;
    localparam logic [5:0]  OPX_TRAPRET   = 6'h09;
    localparam logic [5:0]  OPX_CALLR     = 6'h1D;
    // Status word bits
    localparam int          ST_IE_BIT     = 0;         // Global interrupt enable
    localparam int          ST_U_BIT      = 1;         // User mode
    localparam logic [31:0] STATUS_RST    = 32'h0000_0000;
    localparam logic [31:0] REG_RST       = 32'h0000_0000;
    localparam logic [31:0] PC_STEP       = 32'h0000_0004;
    localparam logic [1:0]  ALIGN_ZERO    = 2'h0;
    localparam logic [31:0] TRAP_VEC_DEF  = 32'h0000_0020;  // Arbitrary default
    localparam logic [31:0] RESET_PC_DEF  = 32'h0000_0000;
endpackage

// ### verilog/branch_call_unit.sv
// Control-transfer decode and execute unit: branches, trap, return, calls
`timescale 1ns/1ps
// Summary of operation
// - Signed less-than branch picks relative target
// - Unsigned less-than branch picks relative target
// - Relative jump always takes relative target
// - Offset counts bytes from PC plus four
// - Misaligned computed target raises exception
// - Branch fields: A, B, offset, opcode
// - Trap saves status, clears bits, vectors
// - Trap type field ignored by hardware
// - Trap vector fixed at build time
// - Trap return restores status, supervisor only
// - Direct call links, keeps region bits
// - Jump format: target field, opcode zero
// - Direct call never carries into region
// - Register call links, jumps to register
module branch_call_unit
    import branch_call_pkg::*;
#(
    parameter logic [31:0] TRAP_VECTOR = TRAP_VEC_DEF,  // Fixed trap handler address
    parameter logic [31:0] RESET_PC    = RESET_PC_DEF   // PC after reset
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              instr_valid,     // Instruction presented this cycle
    input  wire logic [XLEN-1:0]   instr_word,      // Instruction word
    input  wire logic [XLEN-1:0]   opnd_a,          // First operand register value
    input  wire logic [XLEN-1:0]   opnd_b,          // Second operand register value
    input  wire logic              status_load,     // Status write from control logic
    input  wire logic [XLEN-1:0]   status_load_data, // Value for that status write
    output logic [REG_IDX_W-1:0]   opnd_a_idx,      // First operand index to register file
    output logic [REG_IDX_W-1:0]   opnd_b_idx,      // Second operand index to register file
    output logic                   handled,         // Instruction belongs to this unit
    output logic [XLEN-1:0]        pc_q,            // Program counter
    output logic [XLEN-1:0]        status_q,        // Status word
    output logic [XLEN-1:0]        saved_status_q,  // Saved trap status
    output logic [XLEN-1:0]        resume_q,        // Trap resume address
    output logic [XLEN-1:0]        link_register_q, // Subroutine link value
    output logic                   link_wr_q,       // Link write pulse
    output logic                   misalign_exc_q,  // Misaligned target pulse
    output logic                   priv_exc_q,      // Supervisor-only pulse
    output logic                   trap_exc_q       // Trap taken pulse
);

    // Decoded kinds of instruction
    typedef enum logic [3:0] {
        K_NONE  = 4'b0000,
        K_BLT   = 4'b0001,
        K_BLTU  = 4'b0010,
        K_BNE   = 4'b0011,
        K_JUMP  = 4'b0100,
        K_TRAP  = 4'b0101,
        K_TRET  = 4'b0110,
        K_CALL  = 4'b0111,
        K_CALLR = 4'b1000
    } kind_t;

    kind_t                    kind;          // Current instruction kind
    logic [OP_W-1:0]          opcode;        // Primary opcode
    logic [OPX_W-1:0]         opx;           // Extended opcode
    logic [OFS_W-1:0]         offset_field;  // Relative offset
    logic [JT_W-1:0]          jump_target_field; // Direct call target
    logic [TT_W-1:0]          trap_type_field;   // Debugger-only field
    logic [XLEN-1:0]          seq_pc;        // PC plus four
    logic [XLEN-1:0]          rel_pc;        // Relative target
    logic [XLEN-1:0]          call_pc;       // Direct call target
    logic                     take;          // Branch condition met
    logic [XLEN-1:0]          target;        // Chosen next PC
    logic                     checks_align;  // Kind is subject to alignment check
    logic                     misaligned;    // Target low bits nonzero
    logic                     user_mode;     // Current mode is user

    // Field extraction
    // Branch, register and jump format fields, and the mode bit
    assign opnd_a_idx   = instr_word[RA_HI:RA_LO];
    assign opnd_b_idx   = instr_word[RB_HI:RB_LO];
    assign offset_field = instr_word[OFS_HI:OFS_LO];
    assign opcode       = instr_word[OP_HI:OP_LO];
    assign opx          = instr_word[OPX_HI:OPX_LO];
    assign jump_target_field = instr_word[JT_HI:JT_LO];
    assign trap_type_field   = instr_word[TT_HI:TT_LO];
    assign user_mode    = status_q[ST_U_BIT];

    // Opcode decode
    always_comb begin
        kind = K_NONE;
        unique case (opcode)
            OP_BLT:     kind = K_BLT;
            OP_BLTU:    kind = K_BLTU;
            OP_BNE:     kind = K_BNE;
            OP_RELJUMP: kind = K_JUMP;
            OP_CALL:    kind = K_CALL;
            OP_RTYPE: begin
                // Extended opcode selects the register-format kind
                if (opx == OPX_TRAP) begin
                    kind = K_TRAP;
                end else if (opx == OPX_TRAPRET) begin
                    kind = K_TRET;
                end else if (opx == OPX_CALLR) begin
                    kind = K_CALLR;
                end
            end
            default:    kind = K_NONE;
        endcase
    end
    assign handled = instr_valid && (kind != K_NONE);

    // Target arithmetic
    // Displacement measured from PC plus four
    assign seq_pc  = pc_q + PC_STEP;
    assign rel_pc  = seq_pc + {{(XLEN-OFS_W){offset_field[OFS_W-1]}}, offset_field};
    // Region bits copied, no carry possible
    assign call_pc = {pc_q[REGION_HI:REGION_LO], jump_target_field, ALIGN_ZERO};

    // Condition and target selection
    always_comb begin
        take         = 1'b0;
        target       = seq_pc;
        checks_align = 1'b0;
        unique case (kind)
            K_BLT:   take = $signed(opnd_a) < $signed(opnd_b);
            K_BLTU:  take = opnd_a < opnd_b;
            K_BNE:   take = opnd_a != opnd_b;
            K_JUMP:  take = 1'b1;
            default: take = 1'b0;
        endcase
        if (kind inside {K_BLT, K_BLTU, K_BNE, K_JUMP}) begin
            checks_align = take;
            target       = take ? rel_pc : seq_pc;
        end else if (kind == K_TRAP) begin
            target = TRAP_VECTOR;
        end else if (kind == K_TRET) begin
            checks_align = 1'b1;
            target       = resume_q;
        end else if (kind == K_CALL) begin
            target = call_pc;
        end else if (kind == K_CALLR) begin
            checks_align = 1'b1;
            target       = opnd_a;
        end
    end
    assign misaligned = checks_align && (target[1:0] != ALIGN_ZERO);

    // Program counter; a faulting target is left for exception logic to redirect
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pc_q <= RESET_PC;
        end else if (instr_valid) begin
            if (kind == K_TRET && user_mode) begin
                pc_q <= pc_q;                    // Privilege fault, no transfer
            end else if (!misaligned) begin
                pc_q <= target;
            end
        end
    end

    // Status word and saved copy
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_q       <= STATUS_RST;
            saved_status_q <= STATUS_RST;
        end else if (handled && kind == K_TRAP) begin
            // Save status, clear enable and user
            saved_status_q              <= status_q;
            status_q                    <= status_q;
            status_q[ST_IE_BIT]         <= 1'b0;
            status_q[ST_U_BIT]          <= 1'b0;
        end else if (handled && kind == K_TRET && !user_mode && !misaligned) begin
            status_q <= saved_status_q;
        end else if (status_load) begin
            // Outside write; without it user mode could never be entered
            status_q <= status_load_data;
        end
    end

    // Resume address, written only by the trap
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            resume_q <= REG_RST;
        end else if (handled && kind == K_TRAP) begin
            resume_q <= seq_pc;
        end
    end

    // Link register write for both calls
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            link_register_q <= REG_RST;
            link_wr_q       <= 1'b0;
        end else begin
            link_wr_q <= 1'b0;
            if (handled && (kind == K_CALL || (kind == K_CALLR && !misaligned))) begin
                link_register_q <= seq_pc;
                link_wr_q       <= 1'b1;
            end
        end
    end

    // Exception pulses, one cycle each
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            misalign_exc_q <= 1'b0;
            priv_exc_q     <= 1'b0;
            trap_exc_q     <= 1'b0;
        end else begin
            priv_exc_q     <= handled && kind == K_TRET && user_mode;
            misalign_exc_q <= handled && misaligned && !(kind == K_TRET && user_mode);
            trap_exc_q     <= handled && kind == K_TRAP;
        end
    end

    // Checks
    // Signed branch target
    blt_target_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (instr_valid && kind == K_BLT && $signed(opnd_a) < $signed(opnd_b) && !misaligned)
        |=> pc_q == $past(rel_pc)) else $error("signed branch target wrong");
    bltu_target_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (instr_valid && kind == K_BLTU && opnd_a < opnd_b && !misaligned)
        |=> pc_q == $past(pc_q) + PC_STEP
            + {{(XLEN-OFS_W){$past(offset_field[OFS_W-1])}}, $past(offset_field)})
        else $error("unsigned branch target wrong");
    bne_fall_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (instr_valid && kind == K_BNE && opnd_a == opnd_b)
        |=> pc_q == $past(pc_q) + PC_STEP) else $error("not-equal branch taken on equal");
    // Misaligned target leaves PC and raises fault
    misalign_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (instr_valid && misaligned && kind != K_TRET)
        |=> misalign_exc_q && $stable(pc_q)) else $error("misaligned target not faulted");
    trap_effect_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (handled && kind == K_TRAP) |=> pc_q == TRAP_VECTOR && resume_q == $past(seq_pc)
        && !status_q[ST_IE_BIT] && !status_q[ST_U_BIT] && saved_status_q == $past(status_q))
        else $error("trap effects wrong");
    tret_priv_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (handled && kind == K_TRET && user_mode && !status_load)
        |=> priv_exc_q && $stable(status_q))
        else $error("user-mode return not faulted");
    call_region_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (handled && kind == K_CALL)
        |=> pc_q[REGION_HI:REGION_LO] == $past(pc_q[REGION_HI:REGION_LO]) && link_wr_q)
        else $error("call left region");
    callr_link_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (handled && kind == K_CALLR && !misaligned)
        |=> pc_q == $past(opnd_a) && link_register_q == $past(pc_q) + PC_STEP)
        else $error("register call wrong");
    untaken_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (instr_valid && kind inside {K_BLT, K_BLTU, K_BNE} && !take && !status_load)
        |=> $stable(status_q) && $stable(link_register_q) && !link_wr_q && !misalign_exc_q)
        else $error("untaken branch changed state");

    trap_seen_c:   cover property (@(posedge mclk) disable iff (!rst_n) trap_exc_q);
    tret_ok_c:     cover property (@(posedge mclk) disable iff (!rst_n)
        handled && kind == K_TRET && !user_mode && !misaligned);
    misalign_c:    cover property (@(posedge mclk) disable iff (!rst_n) misalign_exc_q);
    call_link_c:   cover property (@(posedge mclk) disable iff (!rst_n) link_wr_q);
    priv_fault_c:  cover property (@(posedge mclk) disable iff (!rst_n) priv_exc_q);

endmodule // branch_call_unit

// ### bench/regfile_model.sv
// Behavioural register file standing on the far side of the operand ports
`timescale 1ns/1ps
module regfile_model
    import branch_call_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 wr_en,     // Bench load strobe
    input  wire logic [REG_IDX_W-1:0] wr_idx,    // Register to load
    input  wire logic [XLEN-1:0]      wr_data,   // Value to load
    input  wire logic [REG_IDX_W-1:0] rd_a_idx,  // First read index from the unit
    input  wire logic [REG_IDX_W-1:0] rd_b_idx,  // Second read index from the unit
    output logic      [XLEN-1:0]      rd_a,      // First read value
    output logic      [XLEN-1:0]      rd_b       // Second read value
);
    logic [XLEN-1:0] regs [32];  // Storage, cleared at start

    // Clear storage so reads never return unknowns
    initial begin
        foreach (regs[i]) regs[i] = REG_RST;
    end

    // Loads come only from the bench, one per edge
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            regs[wr_idx] <= wr_data;
        end
    end

    // Same-cycle reads, as the unit expects its operands combinationally
    assign rd_a = regs[rd_a_idx];
    assign rd_b = regs[rd_b_idx];
endmodule // regfile_model

// ### bench/branch_call_unit_tb_top.sv
// Self-checking bench for the control-transfer unit
`timescale 1ns/1ps
module branch_call_unit_tb_top
    import branch_call_pkg::*;
;
    localparam logic [31:0] TRAPV = 32'h0000_0100;  // Build-time handler address
    logic                 mclk, rst_n, instr_valid, wr_en;
    logic [XLEN-1:0]      instr_word, opnd_a, opnd_b, wr_data, p;
    logic [REG_IDX_W-1:0] opnd_a_idx, opnd_b_idx, wr_idx;
    logic [XLEN-1:0]      pc_q, status_q, saved_status_q, resume_q, link_register_q;
    logic                 handled, link_wr_q, misalign_exc_q, priv_exc_q, trap_exc_q;
    logic                 status_load, h_seen;  // Status write strobe; handled as seen
    logic [XLEN-1:0]      status_load_data;     // Status write value
    int                   n_errors   = 0;  // Mismatch count
    int                   num_checks = 0;  // Comparison count

    branch_call_unit #(.TRAP_VECTOR(TRAPV)) u_branch_call_unit (
        .mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
        .opnd_a(opnd_a), .opnd_b(opnd_b), .opnd_a_idx(opnd_a_idx), .opnd_b_idx(opnd_b_idx),
        .status_load(status_load), .status_load_data(status_load_data),
        .handled(handled), .pc_q(pc_q), .status_q(status_q), .saved_status_q(saved_status_q),
        .resume_q(resume_q), .link_register_q(link_register_q), .link_wr_q(link_wr_q),
        .misalign_exc_q(misalign_exc_q), .priv_exc_q(priv_exc_q), .trap_exc_q(trap_exc_q));

    regfile_model u_regfile_model (
        .mclk(mclk), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
        .rd_a_idx(opnd_a_idx), .rd_b_idx(opnd_b_idx), .rd_a(opnd_a), .rd_b(opnd_b));

    // Free-running 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Compare and count; four-state equality so unknowns fail
    // Wide enough that flag bits joined to a 32-bit word are compared too
    task automatic check(input logic [71:0] seen, input logic [71:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Verdict and the single exit point
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Load one register of the partner model
    task automatic set_reg(input logic [4:0] i, input logic [31:0] v);
        @(posedge mclk);
        wr_en   <= 1'b1;
        wr_idx  <= i;
        wr_data <= v;
        @(posedge mclk);
        wr_en   <= 1'b0;
    endtask

    // Issue one instruction; returns just after the edge that takes it
    task automatic exec(input logic [31:0] w);
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr_word  <= w;
        #1;
        h_seen = handled;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
    endtask

    // Branch-format word; offsets kept word aligned unless a fault is wanted
    function automatic logic [31:0] bw(input logic [4:0] a, input logic [4:0] b,
                                       input logic [15:0] o, input logic [5:0] op);
        return {a, b, o, op};
    endfunction

    // Cut a hang short; the sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge mclk);
        n_errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0; instr_valid = 1'b0; instr_word = 32'h0000_0000;
        wr_en = 1'b0; wr_idx = 5'h00; wr_data = 32'h0000_0000;
        status_load = 1'b0; status_load_data = 32'h0000_0000; h_seen = 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        check(pc_q, 32'h0000_0000, "reset pc");
        check(status_q | saved_status_q | resume_q | link_register_q, 32'h0, "reset regs");
        set_reg(5'h01, 32'hFFFF_FFFF);
        set_reg(5'h02, 32'h0000_0001);
        set_reg(5'h03, 32'hF000_0000);
        set_reg(5'h04, 32'h0000_0102);
        set_reg(5'h05, 32'h0000_0001);
        exec(bw(5'h00, 5'h00, 16'h7FFC, OP_RELJUMP));
        check(pc_q, 32'h0000_8000, "jump fwd");
        check(h_seen, 1'b1, "jump handled");
        exec(bw(5'h01, 5'h02, 16'hFFF8, OP_BLT));
        check(pc_q, 32'h0000_7FFC, "blt signed");
        check({opnd_a_idx, opnd_b_idx}, {5'h01, 5'h02}, "fields");
        exec(bw(5'h01, 5'h02, 16'h0100, OP_BLTU));
        p = 32'h0000_8000;
        check(pc_q, p, "bltu untaken");
        check({link_wr_q, link_register_q, status_q}, 65'h0, "untaken state");
        exec(bw(5'h02, 5'h01, 16'h0100, OP_BLTU));
        p = p + 32'h4 + 32'h100;
        check(pc_q, p, "bltu taken");
        exec(bw(5'h02, 5'h01, 16'h0100, OP_BLT));
        p = p + 32'h4;
        check(pc_q, p, "blt untaken");
        exec(bw(5'h02, 5'h05, 16'h0040, OP_BNE));
        p = p + 32'h4;
        check(pc_q, p, "bne equal");
        exec(bw(5'h01, 5'h02, 16'h0010, OP_BNE));
        p = p + 32'h14;
        check(pc_q, p, "bne differ");
        exec(bw(5'h00, 5'h00, 16'h0006, OP_RELJUMP));
        check({misalign_exc_q, pc_q}, {1'b1, p}, "jump misalign");
        exec(bw(5'h01, 5'h02, 16'h0002, OP_BLT));
        check({misalign_exc_q, pc_q}, {1'b1, p}, "blt misalign");
        exec(bw(5'h00, 5'h00, 16'h0000, 6'h3F));
        // A foreign opcode is not ours, yet the PC still steps past it
        p = p + 32'h4;
        check(pc_q, p, "unknown op");
        check(h_seen, 1'b0, "unknown not handled");
        // User mode with interrupts on, so the trap has bits to save and clear
        @(posedge mclk);
        status_load      <= 1'b1;
        status_load_data <= 32'h0000_0003;
        @(posedge mclk);
        status_load      <= 1'b0;
        #1;
        check(status_q, 32'h0000_0003, "status load");
        // Trap with a nonzero type field
        exec({5'h00, 5'h00, 5'h1E, OPX_TRAP, 5'h1F, OP_RTYPE});
        check(pc_q, TRAPV, "trap vector");
        check(resume_q, p + 32'h4, "trap resume");
        check({trap_exc_q, status_q[1:0], saved_status_q},
              {1'b1, 2'b00, 32'h0000_0003}, "trap status");
        exec({5'h1E, 5'h00, 5'h00, OPX_TRAPRET, 5'h00, OP_RTYPE});
        p = p + 32'h4;
        check({priv_exc_q, pc_q, status_q}, {1'b0, p, 32'h0000_0003}, "trap return");
        // Restored status is user mode, so a second return must fault
        exec({5'h1E, 5'h00, 5'h00, OPX_TRAPRET, 5'h00, OP_RTYPE});
        check({priv_exc_q, misalign_exc_q, pc_q, status_q},
              {1'b1, 1'b0, p, 32'h0000_0003}, "user return");
        exec({5'h03, 5'h00, 5'h1F, OPX_CALLR, 5'h00, OP_RTYPE});
        check({link_wr_q, link_register_q}, {1'b1, p + 32'h4}, "callr link");
        check(pc_q, 32'hF000_0000, "callr pc");
        exec({26'h3FF_FFFF, OP_CALL});
        check(pc_q, 32'hFFFF_FFFC, "call region");
        check({link_wr_q, link_register_q}, 33'h1_F000_0004, "call link");
        exec({26'h000_0001, OP_CALL});
        check(pc_q, 32'hF000_0004, "call small");
        exec({5'h04, 5'h00, 5'h1F, OPX_CALLR, 5'h00, OP_RTYPE});
        check({misalign_exc_q, link_wr_q}, 2'b10, "callr misalign");
        check(pc_q, 32'hF000_0004, "callr held");
        end_of_test();
    end
endmodule // branch_call_unit_tb_top
